// [rtl/mcs_array_decode.sv]
// mcs_array_decode: array size and chip type
// from the boards plugged into the backplane.
// assumes board presence levels steady.
`timescale 1ns/1ps
module mcs_array_decode
   import mcs_pkg::*;
(
   // boards
   input  wire logic [NBRD-1:0] brd_present,
   input  wire logic [NBRD-1:0] brd_16k,
   // decoded
   output logic      [5:0]      size_code,
   output logic      [1:0]      chip_type
);
   logic [6:0] units;
   logic       any4;
   logic       any16;

   // ****************
   // capacity sum
   // ****************
   always_comb begin
      units = '0;
      any4  = 1'b0;
      any16 = 1'b0;
      for (int i = 0; i < NBRD; i++) begin
         if (brd_present[i]) begin
            units = units + (brd_16k[i] ? U_16K : U_4K);
            any16 = any16 | brd_16k[i];
            any4  = any4 | ~brd_16k[i];
         end
      end
   end

   // size n means (n+1) x 64K; 4K-only codes stay under 16
   always_comb begin
      if (units == '0)
         size_code = '0; // R09
      else if (units >= U_MAX)
         size_code = 6'h3F;
      else
         size_code = 6'(units - 7'h01); // R09 R10
   end

   always_comb begin
      chip_type = {any16, any4}; // R12
   end
endmodule

// [rtl/mcs_cfg_status.sv]
// mcs_cfg_status: configuration/status register a,
// interrupt status and mask, and the i/o data mux.
// assumes AXI4-Lite master, bus events one-cycle pulses, power sequence levels.
`timescale 1ns/1ps
module mcs_cfg_status
   import mcs_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   // bus events
   input  wire mcs_evt_t          evt,
   // array boards
   input  wire logic [NBRD-1:0]   brd_present,
   input  wire logic [NBRD-1:0]   brd_16k,
   // i/o data mux
   input  wire logic              io_rd_en,
   input  wire mcs_sel_t          io_sel,
   input  wire logic [31:0]       regb_data,
   input  wire logic [31:0]       regc_data,
   input  wire logic [31:0]       rom_data,
   output mcs_fib_t               fib_ff,
   output logic                   fib_valid_ff,
   // interrupt
   output logic                   irq
);
   // ****************
   // declarations
   // ****************
   logic [31:0]       stat_ff;
   logic [31:0]       istat_ff;
   logic [31:0]       imask_ff;
   logic [2:0]        ilv_ff;
   logic              ilk_ff;
   logic              wm_pend_ff;
   logic              xp_ff;
   logic [ID_W-1:0]   xid_ff;
   logic              pup_d_ff;
   logic              pdn_d_ff;
   logic              aw_got_ff;
   logic              w_got_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              s_bvalid_ff;
   logic [1:0]        s_bresp_ff;
   logic              s_rvalid_ff;
   logic [31:0]       s_rdata_ff;
   logic [1:0]        s_rresp_ff;
   logic [5:0]        size_code;
   logic [1:0]        chip_type;
   logic [31:0]       reg_a;
   logic [31:0]       ev;
   logic [31:0]       nxt_stat;
   logic [31:0]       w1c;
   logic              do_wr;
   logic              wr_a;
   logic              wr_is;
   logic              wr_im;
   // ****************
   // helpers
   // ****************
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] ofs);
      return a == ofs;
   endfunction
   function automatic logic [31:0] lanes(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction
   mcs_array_decode u_dec (
      .brd_present (brd_present),
      .brd_16k     (brd_16k),
      .size_code   (size_code),
      .chip_type   (chip_type)
   );
   // ****************
   // register a view
   // ****************
   always_comb begin
      reg_a = stat_ff & ~RSVD_BITS; // R03 R16
      if (chip_type == TY_4K)
         reg_a[SZ_HI:SZ_LO] = {2'h0, size_code[3:0]}; // R10
      else
         reg_a[SZ_HI:SZ_LO] = size_code; // R09
      reg_a[TY_HI:TY_LO] = chip_type; // R12
      reg_a[ILV_HI:0]    = ilv_ff; // R13
   end
   // ****************
   // write channel
   // ****************
   assign s_awready = !aw_got_ff && !s_bvalid_ff;
   assign s_wready  = !w_got_ff && !s_bvalid_ff;
   assign do_wr     = aw_got_ff && w_got_ff && !s_bvalid_ff;
   assign wr_a      = do_wr && hit(awaddr_ff, OFS_CFG_A);
   assign wr_is     = do_wr && hit(awaddr_ff, OFS_ISTAT);
   assign wr_im     = do_wr && hit(awaddr_ff, OFS_IMASK);
   assign w1c       = wdata_ff & lanes(wstrb_ff);
   assign s_bvalid  = s_bvalid_ff;
   assign s_bresp   = s_bresp_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         awaddr_ff <= '0;
      end else if (s_awvalid && s_awready) begin
         aw_got_ff <= 1'b1;
         awaddr_ff <= s_awaddr;
      end else if (do_wr) begin
         aw_got_ff <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_ff <= 1'b0;
         wdata_ff <= WORD_ZERO;
         wstrb_ff <= '0;
      end else if (s_wvalid && s_wready) begin
         w_got_ff <= 1'b1;
         wdata_ff <= s_wdata;
         wstrb_ff <= s_wstrb;
      end else if (do_wr) begin
         w_got_ff <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid_ff <= 1'b0;
         s_bresp_ff  <= RESP_OKAY;
      end else if (do_wr) begin
         s_bvalid_ff <= 1'b1;
         s_bresp_ff  <= (wr_a || wr_is || wr_im) ? RESP_OKAY
                                                  : RESP_SLV;
      end else if (s_bready) begin
         s_bvalid_ff <= 1'b0;
      end
   end
   // ****************
   // read channel
   // ****************
   assign s_arready = !s_rvalid_ff;
   assign s_rvalid  = s_rvalid_ff;
   assign s_rdata   = s_rdata_ff;
   assign s_rresp   = s_rresp_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid_ff <= 1'b0;
         s_rdata_ff  <= WORD_ZERO;
         s_rresp_ff  <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid_ff <= 1'b1;
         s_rresp_ff  <= RESP_OKAY;
         if (hit(s_araddr, OFS_CFG_A))
            s_rdata_ff <= reg_a;
         else if (hit(s_araddr, OFS_ISTAT))
            s_rdata_ff <= istat_ff;
         else if (hit(s_araddr, OFS_IMASK))
            s_rdata_ff <= imask_ff;
         else begin
            s_rdata_ff <= WORD_ZERO;
            s_rresp_ff <= RESP_SLV;
         end
      end else if (s_rready) begin
         s_rvalid_ff <= 1'b0;
      end
   end
   // ****************
   // event sequencing
   // ****************
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ilk_ff <= 1'b0;
      else if (evt.irm_cmd)
         ilk_ff <= 1'b1;
      else if (evt.iwm_cmd)
         ilk_ff <= 1'b0;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wm_pend_ff <= 1'b0;
         xp_ff      <= 1'b0;
         xid_ff     <= '0;
         pup_d_ff   <= 1'b0;
         pdn_d_ff   <= 1'b0;
      end else begin
         wm_pend_ff <= evt.wm_cmd || evt.iwm_cmd;
         xp_ff      <= evt.xmit_cycle;
         xid_ff     <= evt.xmit_id;
         pup_d_ff   <= evt.pwr_up_seq;
         pdn_d_ff   <= evt.pwr_dn_seq;
      end
   end
   always_comb begin
      ev         = WORD_ZERO;
      ev[B_PAR]  = evt.parity_err; // R01
      ev[B_WSEQ] = wm_pend_ff && !evt.wdata_fmt; // R02
      ev[B_ILK]  = evt.iwm_cmd && !ilk_ff; // R04
      ev[B_MULT] = xp_ff && (evt.rx_id != xid_ff); // R05
      ev[B_XMIT] = evt.xmit_fault; // R06
      ev[B_PUP]  = evt.pwr_up_seq; // R07
      ev[B_PDN]  = evt.pwr_dn_seq; // R08
   end
   // ****************
   // status bits
   // ****************
   always_comb begin
      nxt_stat = stat_ff;
      if (evt.fault_clr)
         nxt_stat[B_ILK:B_MULT] = '0;
      if (evt.fault_clr)
         nxt_stat[B_PAR:B_WSEQ] = '0;
      if (wr_a) begin
         nxt_stat[B_XMIT] = stat_ff[B_XMIT] & ~w1c[B_XMIT]; // R06
         nxt_stat[B_PUP]  = stat_ff[B_PUP] & ~w1c[B_PUP]; // R07
         nxt_stat[B_PDN]  = stat_ff[B_PDN] & ~w1c[B_PDN]; // R08
      end
      nxt_stat = (nxt_stat | ev) & EVT_BITS; // R16
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         stat_ff <= WORD_ZERO;
      else
         stat_ff <= nxt_stat;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ilv_ff <= ILV_RST;
      else if (wr_a && w1c[B_ILV_WE] && wstrb_ff[0])
         ilv_ff <= wdata_ff[ILV_HI:0]; // R11 R13
   end
   // ****************
   // interrupt
   // ****************
   logic [31:0] edge_ev;
   always_comb begin
      edge_ev        = ev;
      edge_ev[B_PUP] = evt.pwr_up_seq && !pup_d_ff;
      edge_ev[B_PDN] = evt.pwr_dn_seq && !pdn_d_ff;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         istat_ff <= WORD_ZERO;
      else if (wr_is)
         istat_ff <= (istat_ff & ~w1c) | edge_ev;
      else
         istat_ff <= istat_ff | edge_ev;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         imask_ff <= WORD_ZERO;
      else if (wr_im)
         imask_ff <= ((imask_ff & ~lanes(wstrb_ff))
                     | w1c) & EVT_BITS;
   end
   assign irq = |(istat_ff & imask_ff);
   // ****************
   // i/o data mux
   // ****************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fib_ff       <= '0;
         fib_valid_ff <= 1'b0;
      end else begin
         fib_valid_ff <= io_rd_en;
         fib_ff.mask  <= MASK_ZERO; // R15
         if (io_rd_en) begin
            unique case (io_sel)
               MCS_SEL_A:   fib_ff.data <= reg_a; // R14
               MCS_SEL_B:   fib_ff.data <= regb_data;
               MCS_SEL_C:   fib_ff.data <= regc_data;
               MCS_SEL_ROM: fib_ff.data <= rom_data;
            endcase
         end
      end
   end
   // ****************
   // checks
   // ****************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_parity_set: assert property ( // R01
      evt.parity_err ##1 !evt.fault_clr
      |-> stat_ff[B_PAR] ##1 stat_ff[B_PAR])
      else $error("parity fault flag not set");
   a_wseq_set: assert property ( // R02
      evt.wm_cmd ##1 !evt.wdata_fmt |=> stat_ff[B_WSEQ])
      else $error("write sequence flag not set");
   a_bit29_zero: assert property ( // R03
      s_rvalid |-> !s_rdata[29]) else $error("bit 29 read non-zero");
   a_ilk_fault: assert property ( // R04
      evt.irm_cmd ##1 (evt.iwm_cmd && !evt.irm_cmd) |=> !$rose(stat_ff[B_ILK]))
      else $error("interlock flag set after read");
   a_multi_xmit: assert property ( // R05
      evt.xmit_cycle ##1 (evt.rx_id != $past(evt.xmit_id)) |=> stat_ff[B_MULT])
      else $error("multiple transmitter flag missed");
   a_xmit_w1c: assert property ( // R06
      wr_a && w1c[B_XMIT] && !evt.xmit_fault
      |=> !stat_ff[B_XMIT]) else $error("transmit fault not cleared");
   a_pwr_hold: assert property ( // R07
      evt.pwr_up_seq [*2] |=> stat_ff[B_PUP])
      else $error("power-up flag dropped");
   a_pdn_hold: assert property ( // R08
      evt.pwr_dn_seq |=> stat_ff[B_PDN]) else $error("power-down flag dropped");
   a_size_4k: assert property ( // R10
      chip_type == TY_4K |-> reg_a[SZ_HI:SZ_HI-1] == 2'h0)
      else $error("4K size upper bits set");
   a_ilv_guard: assert property ( // R11
      (wr_a && !wdata_ff[B_ILV_WE]) |=> $stable(ilv_ff))
      else $error("interleave written without enable");
   a_fib_mask: assert property ( // R15
      fib_valid_ff |-> fib_ff.mask == MASK_ZERO)
      else $error("non-zero mask on i/o read");
   a_rsvd_zero: assert property ( // R16
      (reg_a & RSVD_BITS) == WORD_ZERO) else $error("reserved bits non-zero");
   a_fib_sel: assert property ( // R14
      io_rd_en && io_sel == MCS_SEL_ROM
      |=> fib_valid_ff && fib_ff.data == $past(rom_data))
      else $error("rom word not on info bus");
endmodule

// [rtl/mcs_pkg.sv]
// mcs_pkg: constants and types of the memory
// configuration status register block.
// assumes AXI4-Lite register access, one clock.
//
// Summary of operation
// R01 - bus parity error sets read-only bit 31
// R02 - masked write without following write data sets bit 30
// R03 - bit 29 always reads zero
// R04 - interlocked write without interlock set sets bit 28
// R05 - received id differing from sent id sets bit 27
// R06 - fault while transmitting sets bit 26, write one clears
// R07 - bit 23 held set during power-up, write one clears
// R08 - bit 22 held set during power-down, write one clears
// R09 - size field 14:9 holds 64K units minus one
// R10 - 4K chip arrays leave size bits 14:13 unused
// R11 - interleave field changes only when write has bit 8 set
// R12 - bits 4:3 give chip type from boards present
// R13 - bits 2:0 hold readable, writable interleave status
// R14 - selected register or ROM word driven onto info bus
// R15 - all-zero mask sent with every register or ROM word
// R16 - unassigned bits read zero, writes ignored
package mcs_pkg;
   // ****************
   // register map
   // ****************
   localparam int        ADDR_W     = 8;
   localparam [7:0]      OFS_CFG_A  = 8'h00;
   localparam [7:0]      OFS_ISTAT  = 8'h04;
   localparam [7:0]      OFS_IMASK  = 8'h08;
   localparam [1:0]      RESP_OKAY  = 2'h0;
   localparam [1:0]      RESP_SLV   = 2'h2;
   // ****************
   // fields of register a
   // ****************
   localparam int        B_PAR      = 31;
   localparam int        B_WSEQ     = 30;
   localparam int        B_ILK      = 28;
   localparam int        B_MULT     = 27;
   localparam int        B_XMIT     = 26;
   localparam int        B_PUP      = 23;
   localparam int        B_PDN      = 22;
   localparam int        B_ILV_WE   = 8;
   localparam int        SZ_LO      = 9;
   localparam int        SZ_HI      = 14;
   localparam int        TY_LO      = 3;
   localparam int        TY_HI      = 4;
   localparam int        ILV_HI     = 2;
   localparam [31:0]     EVT_BITS   = 32'hDC_C0_00_00;
   localparam [31:0]     RSVD_BITS  = 32'h23_3F_80_E0;
   localparam [2:0]      ILV_RST    = 3'h0;
   localparam [31:0]     WORD_ZERO  = 32'h0000_0000;
   localparam [3:0]      MASK_ZERO  = 4'h0;
   // ****************
   // array boards
   // ****************
   localparam int        NBRD       = 16;
   localparam [1:0]      TY_NONE    = 2'h0;
   localparam [1:0]      TY_4K      = 2'h1;
   localparam [1:0]      TY_16K     = 2'h2;
   localparam [1:0]      TY_BOTH    = 2'h3;
   localparam [6:0]      U_4K       = 7'h01;
   localparam [6:0]      U_16K      = 7'h04;
   localparam [6:0]      U_MAX      = 7'h40;
   localparam int        ID_W       = 5;
   // ****************
   // types
   // ****************
   typedef enum logic [1:0] {
      MCS_SEL_A, MCS_SEL_B, MCS_SEL_C, MCS_SEL_ROM
   } mcs_sel_t;
   typedef struct packed {
      logic            parity_err;
      logic            wm_cmd;
      logic            iwm_cmd;
      logic            irm_cmd;
      logic            wdata_fmt;
      logic            xmit_cycle;
      logic            xmit_fault;
      logic [ID_W-1:0] xmit_id;
      logic [ID_W-1:0] rx_id;
      logic            pwr_up_seq;
      logic            pwr_dn_seq;
      logic            fault_clr;
   } mcs_evt_t;
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  mask;
   } mcs_fib_t;
endpackage

// [verif/mcs_far_model.sv]
// mcs_far_model: command file and requester side of the block,
// producing bus event pulses and power sequence levels.
// assumes one clock and one-cycle requests from the bench.
`timescale 1ns/1ps
module mcs_far_model
   import mcs_pkg::*;
(
   // clock
   input  wire logic       aclk,
   // request
   input  wire logic       go,
   input  wire logic [2:0] op,
   input  wire logic       pu,
   input  wire logic       pd,
   // events
   output mcs_evt_t        evt
);
   // ****************
   // sequencer
   // ****************
   logic [1:0] st_ff   = 2'h0;
   logic [2:0] op_ff   = 3'h0;
   logic [4:0] tick_ff = 5'h00;
   logic       s1;
   logic       s2;
   assign s1 = (st_ff == 2'h1);
   assign s2 = (st_ff == 2'h2);
   always_ff @(posedge aclk) begin
      tick_ff <= tick_ff + 5'h01;
      if (go) begin
         st_ff <= 2'h1;
         op_ff <= op;
      end else if (st_ff != 2'h0) begin
         st_ff <= st_ff + 2'h1;
      end
   end
   // ****************
   // event pulses
   // ****************
   always_comb begin
      evt            = '0;
      evt.pwr_up_seq = pu;
      evt.pwr_dn_seq = pd;
      // id lines show no stale value outside their cycle
      evt.xmit_id    = tick_ff;
      evt.rx_id      = ~tick_ff;
      case (op_ff)
         3'h0: evt.parity_err = s1;
         3'h1: evt.wm_cmd = s1;
         3'h2: begin
            evt.iwm_cmd   = s1;
            evt.wdata_fmt = s2;
         end
         3'h3: begin
            evt.irm_cmd   = s1;
            evt.iwm_cmd   = s2;
            evt.wdata_fmt = (st_ff == 2'h3);
         end
         3'h4, 3'h5: begin
            evt.xmit_cycle = s1;
            if (s1) evt.xmit_id = 5'h0A;
            if (s2) evt.rx_id = (op_ff == 3'h4) ? 5'h15 : 5'h0A;
         end
         3'h6: begin
            evt.xmit_cycle = s1;
            evt.xmit_fault = s1;
         end
         default: evt.fault_clr = s1;
      endcase
   end
endmodule

// [verif/tb_memory_config_status_reg.sv]
// tb_memory_config_status_reg: self-checking bench of mcs_cfg_status.
// assumes mcs_far_model drives the bus events.
`timescale 1ns/1ps
module tb_memory_config_status_reg
   import mcs_pkg::*;
   ;
   // ****************
   // signals
   // ****************
   logic            aclk      = 1'b0;
   logic            aresetn   = 1'b0;
   logic [7:0]      s_awaddr  = 8'h00;
   logic            s_awvalid = 1'b0;
   logic [31:0]     s_wdata   = 32'h0;
   logic            s_wvalid  = 1'b0;
   logic            s_bready  = 1'b0;
   logic [7:0]      s_araddr  = 8'h00;
   logic            s_arvalid = 1'b0;
   logic            s_rready  = 1'b0;
   logic [15:0]     brd_p     = 16'h0;
   logic [15:0]     brd_16    = 16'h0;
   logic            io_rd_en  = 1'b0;
   mcs_sel_t        io_sel    = MCS_SEL_A;
   logic [31:0]     regb_data = 32'h0;
   logic [31:0]     regc_data = 32'h0;
   logic [31:0]     rom_data  = 32'h0;
   logic            go        = 1'b0;
   logic [2:0]      op        = 3'h0;
   logic            pu        = 1'b0;
   logic            pd        = 1'b0;
   logic            s_awready;
   logic            s_wready;
   logic [1:0]      s_bresp;
   logic            s_bvalid;
   logic            s_arready;
   logic [31:0]     s_rdata;
   logic [1:0]      s_rresp;
   logic            s_rvalid;
   mcs_fib_t        fib;
   logic            fib_vld;
   logic            irq;
   mcs_evt_t        evt;
   logic [35:0]     rq[$];
   logic [35:0]     bq[$];
   logic [35:0]     fq[$];
   int              miscompares = 0;
   int              check_count = 0;
   logic [31:0]     ea = 32'h0;
   always #10 aclk = ~aclk;
   mcs_cfg_status dut_u (.aclk, .aresetn, .s_awaddr, .s_awvalid,
      .s_awready, .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .evt,
      .brd_present(brd_p), .brd_16k(brd_16), .io_rd_en, .io_sel,
      .regb_data, .regc_data, .rom_data, .fib_ff(fib),
      .fib_valid_ff(fib_vld), .irq);
   mcs_far_model far_u (.aclk, .go, .op, .pu, .pd, .evt);
   // ****************
   // compare and monitor
   // ****************
   task summarize;
      if (miscompares == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [35:0] e, input logic [35:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   always @(posedge aclk) begin
      if (s_rvalid && s_rready) chk(rq.pop_front(), {2'h0, s_rresp, s_rdata});
      if (s_bvalid && s_bready) chk(bq.pop_front(), {34'h0, s_bresp});
      if (fib_vld) chk(fq.pop_front(), fib);
   end
   // ****************
   // bus tasks
   // ****************
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_p;
      logic w_p;
      bq.push_back({34'h0, r});
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p) begin
         @(posedge aclk);
         if (aw_p && s_awready) begin
            aw_p = 1'b0;
            s_awvalid <= 1'b0;
         end
         if (w_p && s_wready) begin
            w_p = 1'b0;
            s_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({2'h0, r, d});
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge aclk); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge aclk); while (s_rvalid !== 1'b1);
      s_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task ev(input logic [2:0] o);
      op <= o;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      cyc(5);
   endtask
   // ****************
   // tests
   // ****************
   logic [31:0] bitm [7] = '{32'h8000_0000, 32'h4000_0000, 32'h1000_0000,
      32'h0, 32'h0800_0000, 32'h0, 32'h0400_0000};
   logic [15:0] bp [6] = '{16'h0001, 16'h0003, 16'hFFFF, 16'h0001,
      16'h0003, 16'hFFFF};
   logic [15:0] b16 [6] = '{16'h0, 16'h0, 16'h0, 16'h0001, 16'h0002,
      16'hFFFF};
   logic [5:0]  sz [6] = '{6'h00, 6'h01, 6'h0F, 6'h03, 6'h04, 6'h3F};
   logic [1:0]  ty [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
   initial begin
      logic [2:0]  v;
      logic [31:0] src [4];
      void'($urandom(32'h2B36));
      cyc(12);
      aresetn <= 1'b1;
      cyc(1);
      rd(OFS_CFG_A, 32'h0, RESP_OKAY);
      wr(OFS_IMASK, 32'hFFFF_FFFF, RESP_OKAY);
      rd(OFS_IMASK, EVT_BITS, RESP_OKAY);
      for (int i = 0; i < 7; i++) begin
         ev(3'(i));
         ea |= bitm[i];
         rd(OFS_CFG_A, ea, RESP_OKAY);
         rd(OFS_ISTAT, ea, RESP_OKAY);
      end
      chk(36'h1, {35'h0, irq});
      wr(OFS_CFG_A, 32'hFFFF_FEFF, RESP_OKAY);
      ea[26] = 1'b0;
      rd(OFS_CFG_A, ea, RESP_OKAY);
      ev(3'h7);
      rd(OFS_CFG_A, 32'h0, RESP_OKAY);
      wr(OFS_IMASK, 32'h0, RESP_OKAY);
      chk(36'h0, {35'h0, irq});
      wr(OFS_IMASK, 32'h8000_0000, RESP_OKAY);
      chk(36'h1, {35'h0, irq});
      wr(OFS_ISTAT, 32'hFFFF_FFFF, RESP_OKAY);
      rd(OFS_ISTAT, 32'h0, RESP_OKAY);
      chk(36'h0, {35'h0, irq});
      pu <= 1'b1;
      pd <= 1'b1;
      cyc(3);
      wr(OFS_CFG_A, 32'h00C0_0000, RESP_OKAY);
      rd(OFS_CFG_A, 32'h00C0_0000, RESP_OKAY);
      pu <= 1'b0;
      pd <= 1'b0;
      cyc(2);
      rd(OFS_CFG_A, 32'h00C0_0000, RESP_OKAY);
      wr(OFS_CFG_A, 32'h00C0_0000, RESP_OKAY);
      rd(OFS_CFG_A, 32'h0, RESP_OKAY);
      rd(OFS_ISTAT, 32'h00C0_0000, RESP_OKAY);
      v = 3'($urandom % 7 + 1);
      wr(OFS_CFG_A, {29'h0, v}, RESP_OKAY);
      rd(OFS_CFG_A, 32'h0, RESP_OKAY);
      wr(OFS_CFG_A, {23'h0, 1'b1, 5'h0, v}, RESP_OKAY);
      ea = {29'h0, v};
      rd(OFS_CFG_A, ea, RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         brd_p <= bp[i];
         brd_16 <= b16[i];
         cyc(2);
         ea = {ea[31:15], sz[i], ea[8:5], ty[i], ea[2:0]};
         rd(OFS_CFG_A, ea, RESP_OKAY);
      end
      rd(8'h0C, 32'h0, RESP_SLV);
      wr(8'h0C, 32'hFFFF_FFFF, RESP_SLV);
      rd(OFS_CFG_A, ea, RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
         src = '{ea, $urandom, $urandom, $urandom};
         regb_data <= src[1];
         regc_data <= src[2];
         rom_data <= src[3];
         io_sel <= mcs_sel_t'(s);
         io_rd_en <= 1'b1;
         fq.push_back({src[s], MASK_ZERO});
         @(posedge aclk);
         io_rd_en <= 1'b0;
         cyc(2);
      end
      cyc(3);
      summarize;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      summarize;
   end
endmodule
